/* File: caf_filter_ctrl.sv */
// top: acceptance filter control registers, write lock and message routing
// Operation
// R1 - each filter has an enable bit; one takes part, zero is inactive
// R2 - two-bit mask choice: 00 mask 0, 01 mask 1, 10 mask 2, 11 reserved
// R3 - five-bit destination names receive fifo 0 through 31 for matches
// R4 - mask choice and destination writes apply only while the filter is disabled
// R5 - control register 0 top byte holds filter 3: enable 31, mask 30-29, fifo 28-24
// R6 - control register 0 second byte holds filter 2: enable 23, mask 22-21, fifo 20-16
// R7 - control register 1 bits 15-8 hold filter 5 in the same layout
// R8 - control register 1 low byte holds filter 4: enable 7, mask 6-5, fifo 4-0
// R9 - filters 1 and 0 sit in bits 15-8 and 7-0 of control register 0
// R10 - matching enabled filter routes message to its fifo; disabled never matches
`timescale 1ns/100ps
`default_nettype none
module caf_filter_ctrl
    import caf_pkg::*;
#(
    parameter int NUM_FILTERS = CAF_NUM_FILTERS,
    parameter int ID_W        = CAF_ID_W
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // register port
    input  wire logic [7:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_write,
    input  wire logic            reg_read,
    output logic [31:0]          reg_rdata,
    // message lookup from the receive path
    input  wire logic            msg_valid,
    input  wire logic [ID_W-1:0] msg_id,
    output logic                 route_valid,
    output logic                 route_hit,
    output logic [2:0]           route_filter,
    output logic [4:0]           route_fifo
);
    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks: the byte lanes are laid out for exactly six filters,
    // and an identifier must fit one register word
    if (NUM_FILTERS != CAF_NUM_FILTERS) begin : g_bad_count
        $error("caf_filter_ctrl: layout serves exactly six filters");
    end
    if (ID_W < 1 || ID_W > 32) begin : g_bad_id_w
        $error("caf_filter_ctrl: ID_W must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // storage
    caf_filter_t     filt_reg [NUM_FILTERS];
    logic [ID_W-1:0] fid_reg  [NUM_FILTERS];
    logic [ID_W-1:0] mask_reg [3];
    logic [31:0]     rdata_reg;
    caf_route_t      route_reg;
    logic            rvalid_reg;
    logic [7:0]      msg_cnt_reg;
    logic [7:0]      miss_cnt_reg;

    // field extraction from a control word, used by write path and assertions
    function automatic caf_filter_t byte_field(input logic [31:0] w, input int slot);
        logic [7:0] b;
        caf_filter_t f;
        b = w[slot*CAF_FILTER_BITS +: CAF_FILTER_BITS];
        f.filter_on        = b[CAF_ON_POS];
        f.mask_choice      = b[CAF_MASK_LSB +: CAF_MASK_W];
        f.fifo_destination = b[CAF_DEST_LSB +: CAF_DEST_W];
        return f;
    endfunction

    // byte address of one filter identifier register; write decode and read mux share it
    function automatic logic [7:0] id_offset(input int n);
        return 8'(CAF_OFS_FILTER_ID_0 + n*CAF_ID_STRIDE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // address decode
    wire wr_ctrl0 = reg_write && (reg_addr == CAF_OFS_FILTER_CTRL_0);
    wire wr_ctrl1 = reg_write && (reg_addr == CAF_OFS_FILTER_CTRL_1);
    wire wr_m0    = reg_write && (reg_addr == CAF_OFS_MASK_0);
    wire wr_m1    = reg_write && (reg_addr == CAF_OFS_MASK_1);
    wire wr_m2    = reg_write && (reg_addr == CAF_OFS_MASK_2);

    // assembled control words: filters 0..3 in word 0, 4..5 in word 1
    logic [31:0] ctrl0_word;
    logic [31:0] ctrl1_word;
    assign ctrl0_word = {filt_reg[3], filt_reg[2], filt_reg[1], filt_reg[0]}; // [R5] [R6] [R9]
    assign ctrl1_word = {16'h0000, filt_reg[5], filt_reg[4]};                 // [R7] [R8]

    ////////////////////////////////////////////////////////////////////////////////
    // per filter control and identifier registers
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FILTERS; gi++) begin : g_filt
            localparam int SLOT = gi % CAF_FILTERS_REG0;
            wire         wr_this = (gi < CAF_FILTERS_REG0) ? wr_ctrl0 : wr_ctrl1;
            caf_filter_t wfield;
            assign wfield = byte_field(reg_wdata, SLOT);
            // settings frozen while the filter is on; the enable itself stays writable
            caf_filter_t filt_next;
            assign filt_next.filter_on        = wr_this ? wfield.filter_on : filt_reg[gi].filter_on; // [R1]
            assign filt_next.mask_choice      = (wr_this && !filt_reg[gi].filter_on) ?
                                                wfield.mask_choice : filt_reg[gi].mask_choice;         // [R4] [R2]
            assign filt_next.fifo_destination = (wr_this && !filt_reg[gi].filter_on) ?
                                                wfield.fifo_destination : filt_reg[gi].fifo_destination; // [R4] [R3]
            wire [7:0] id_addr = id_offset(gi);
            wire       wr_id   = reg_write && (reg_addr == id_addr) && !filt_reg[gi].filter_on;

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    filt_reg[gi] <= caf_filter_t'(CAF_CTRL_RESET[7:0]);
                    fid_reg[gi]  <= ID_W'(CAF_ID_RESET);
                end else begin
                    filt_reg[gi] <= filt_next;
                    if (wr_id) begin
                        fid_reg[gi] <= reg_wdata[ID_W-1:0];
                    end
                end
            end

            // an enabled filter must hold its settings whatever software writes
            property p_lock;
                @(posedge clk) disable iff (!resetn)
                filt_reg[gi].filter_on |=> ($stable(filt_reg[gi].mask_choice) &&
                                            $stable(filt_reg[gi].fifo_destination));
            endproperty
            a_lock: assert property (p_lock) else $error("filter setting changed while enabled"); // [R4]

            // a write to a disabled filter loads the whole byte of its own lane
            property p_load;
                @(posedge clk) disable iff (!resetn)
                (wr_this && !filt_reg[gi].filter_on) |=>
                    (filt_reg[gi] == byte_field($past(reg_wdata), SLOT));
            endproperty
            a_load: assert property (p_load) else $error("byte lane not loaded"); // [R5] [R6] [R7] [R8] [R9]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // acceptance masks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_reg[0] <= ID_W'(CAF_ID_RESET);
            mask_reg[1] <= ID_W'(CAF_ID_RESET);
            mask_reg[2] <= ID_W'(CAF_ID_RESET);
        end else begin
            if (wr_m0) mask_reg[0] <= reg_wdata[ID_W-1:0];
            if (wr_m1) mask_reg[1] <= reg_wdata[ID_W-1:0];
            if (wr_m2) mask_reg[2] <= reg_wdata[ID_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // matching: lowest numbered hitting filter wins
    logic [NUM_FILTERS-1:0] hit_vec;
    generate
        for (gi = 0; gi < NUM_FILTERS; gi++) begin : g_match
            caf_match #(
                .ID_W (ID_W)
            ) u_match (
                .msg_id  (msg_id),
                .filt_id (fid_reg[gi]),
                .mask_0  (mask_reg[0]),
                .mask_1  (mask_reg[1]),
                .mask_2  (mask_reg[2]),
                .setting (filt_reg[gi]),
                .hit     (hit_vec[gi])
            );

            // a disabled filter must stay silent whatever its identifier and mask say
            property p_dis;
                @(posedge clk) disable iff (!resetn)
                !filt_reg[gi].filter_on |-> !hit_vec[gi];
            endproperty
            a_dis: assert property (p_dis) else $error("disabled filter produced a match"); // [R1]

            // the lowest hitting filter owns the route; higher ones are shadowed, not merged
            property p_win;
                @(posedge clk) disable iff (!resetn)
                (msg_valid && hit_vec[gi] && ((hit_vec & NUM_FILTERS'((1 << gi) - 1)) == '0)) |=>
                    (route_hit && route_filter == 3'(gi) &&
                     route_fifo == $past(filt_reg[gi].fifo_destination));
            endproperty
            a_win: assert property (p_win) else $error("winning filter not routed to its fifo"); // [R10] [R3]
        end
    endgenerate

    caf_route_t route_sel;
    always_comb begin
        route_sel = '0;
        for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                route_sel.hit    = 1'b1;
                route_sel.filter = 3'(i);
                route_sel.fifo   = filt_reg[i].fifo_destination; // [R10] [R3]
            end
        end
    end

    // the route is registered so downstream sees a clean one-cycle answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            route_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= msg_valid;
            route_reg  <= msg_valid ? route_sel : '0; // [R10]
        end
    end

    // filter 0 has top priority, so any hit on it decides the answer outright
    property p_route;
        @(posedge clk) disable iff (!resetn)
        (msg_valid && hit_vec[0]) |=> (route_valid && route_hit && route_filter == 3'h0 &&
                                       route_fifo == $past(filt_reg[0].fifo_destination));
    endproperty
    a_route: assert property (p_route) else $error("hitting filter 0 not routed to its fifo"); // [R10]

    // with no hit the answer still comes, flagged as a miss
    property p_off;
        @(posedge clk) disable iff (!resetn)
        (msg_valid && hit_vec == '0) |=> (route_valid && !route_hit);
    endproperty
    a_off: assert property (p_off) else $error("message routed with no hitting filter"); // [R1]

    // the reserved code is stored but must never let a message through filter 0
    property p_rsv;
        @(posedge clk) disable iff (!resetn)
        (filt_reg[0].mask_choice == CAF_MASK_SEL_RSV) |-> !hit_vec[0];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved mask code produced a match"); // [R2]

    // no request, no answer: a lingering route pulse would be taken twice downstream
    property p_idle;
        @(posedge clk) disable iff (!resetn)
        !msg_valid |=> (!route_valid && !route_hit);
    endproperty
    a_idle: assert property (p_idle) else $error("route answer without a lookup"); // [R10]

    ////////////////////////////////////////////////////////////////////////////////
    // lookup counters, readable as block status; they wrap
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            msg_cnt_reg  <= 8'h00;
            miss_cnt_reg <= 8'h00;
        end else begin
            if (msg_valid) msg_cnt_reg <= msg_cnt_reg + 8'h01;
            if (msg_valid && !route_sel.hit) miss_cnt_reg <= miss_cnt_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            CAF_OFS_FILTER_CTRL_0: rd_mux = ctrl0_word;
            CAF_OFS_FILTER_CTRL_1: rd_mux = ctrl1_word;
            CAF_OFS_MASK_0:        rd_mux = 32'(mask_reg[0]);
            CAF_OFS_MASK_1:        rd_mux = 32'(mask_reg[1]);
            CAF_OFS_MASK_2:        rd_mux = 32'(mask_reg[2]);
            CAF_OFS_STATUS:        rd_mux = {16'h0000, miss_cnt_reg, msg_cnt_reg};
            default: begin
                for (int i = 0; i < NUM_FILTERS; i++) begin
                    if (reg_addr == id_offset(i)) begin
                        rd_mux = 32'(fid_reg[i]);
                    end
                end
            end
        endcase
    end

    // read data is held only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_read ? rd_mux : 32'h0000_0000;
        end
    end

    // the unused upper half of control register 1 must never show stray bits
    property p_rd;
        @(posedge clk) disable iff (!resetn)
        (reg_read && reg_addr == CAF_OFS_FILTER_CTRL_1) |=> (reg_rdata[31:16] == 16'h0000);
    endproperty
    a_rd: assert property (p_rd) else $error("upper half of control register 1 not zero"); // [R7]

    // control register 0 shows filter 3 down to filter 0, one byte each
    property p_rd0;
        @(posedge clk) disable iff (!resetn)
        (reg_read && reg_addr == CAF_OFS_FILTER_CTRL_0) |=>
            (reg_rdata == {$past(filt_reg[3]), $past(filt_reg[2]), $past(filt_reg[1]), $past(filt_reg[0])});
    endproperty
    a_rd0: assert property (p_rd0) else $error("control register 0 byte lanes misplaced"); // [R5] [R6] [R9]

    // control register 1 shows filter 5 above filter 4 in its low half
    property p_rd1;
        @(posedge clk) disable iff (!resetn)
        (reg_read && reg_addr == CAF_OFS_FILTER_CTRL_1) |=>
            (reg_rdata[15:0] == {$past(filt_reg[5]), $past(filt_reg[4])});
    endproperty
    a_rd1: assert property (p_rd1) else $error("control register 1 byte lanes misplaced"); // [R7] [R8]

    assign reg_rdata    = rdata_reg;
    assign route_valid  = rvalid_reg;
    assign route_hit    = route_reg.hit;
    assign route_filter = route_reg.filter;
    assign route_fifo   = route_reg.fifo;
endmodule
`default_nettype wire

/* File: caf_filter_ctrl_tb.sv */
// self-checking testbench for the acceptance filter control block
`timescale 1ns/100ps
`default_nettype none
module caf_filter_ctrl_tb
    import caf_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    // compare helper: counts every compare, reports and counts mismatches
    `define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin num_errors++; \
        $display("ERROR t=%0t got %h expected %h", $time, (act), (exp)); end end

    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic        msg_valid;
    logic [28:0] msg_id;
    logic        route_valid;
    logic        route_hit;
    logic [2:0]  route_filter;
    logic [4:0]  route_fifo;
    int          num_errors = 0;
    int          checked    = 0;

    caf_filter_ctrl dut_u (
        .clk          (clk),
        .resetn       (resetn),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_write    (reg_write),
        .reg_read     (reg_read),
        .reg_rdata    (reg_rdata),
        .msg_valid    (msg_valid),
        .msg_id       (msg_id),
        .route_valid  (route_valid),
        .route_hit    (route_hit),
        .route_filter (route_filter),
        .route_fifo   (route_fifo)
    );

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // one filter byte: enable, mask choice, fifo destination
    function automatic logic [7:0] fb(input logic on, input logic [1:0] m, input logic [4:0] d);
        return {on, m, d};
    endfunction

    // one-cycle write strobe; a leading edge keeps back-to-back calls from double assignment
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // lookup pulse, answer checked in the next cycle and gone the cycle after
    task automatic look(input logic [28:0] id, input logic hit, input logic [2:0] f, input logic [4:0] q);
        @(posedge clk);
        msg_valid <= 1'b1;
        msg_id    <= id;
        @(posedge clk);
        msg_valid <= 1'b0;
        @(negedge clk);
        `CHK(route_valid, 1'b1)
        `CHK(route_hit, hit)
        if (hit) begin
            `CHK(route_filter, f)
            `CHK(route_fifo, q)
        end else begin
            `CHK(route_filter, 3'h0)
            `CHK(route_fifo, 5'h00)
        end
        @(negedge clk);
        `CHK(route_valid, 1'b0)
        `CHK(route_hit, 1'b0)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_values();
        logic [31:0] d;
        rd(CAF_OFS_FILTER_CTRL_0, d);
        `CHK(d, 32'h0000_0000)
        @(negedge clk);
        `CHK(reg_rdata, 32'h0000_0000)
        rd(CAF_OFS_FILTER_CTRL_1, d);
        `CHK(d, 32'h0000_0000)
    endtask

    // every field of every filter at its own place, upper half of ctrl_1 unused
    task automatic t_layout();
        logic [31:0] d;
        wr(CAF_OFS_FILTER_CTRL_0, {fb(1, 2'h2, 5'h1F), fb(0, 2'h2, 5'h01), fb(1, 2'h1, 5'h03), 8'h00});
        wr(CAF_OFS_FILTER_CTRL_1, 32'hFFFF_3F80);
        rd(CAF_OFS_FILTER_CTRL_0, d);
        `CHK(d, 32'hDF41_A300)
        rd(CAF_OFS_FILTER_CTRL_1, d);
        `CHK(d, 32'h0000_3F80)
    endtask

    // settings of an enabled filter ignore writes; the enable itself always follows
    task automatic t_lock();
        logic [31:0] d;
        wr(CAF_OFS_FILTER_CTRL_0, 32'h809F_0085);
        rd(CAF_OFS_FILTER_CTRL_0, d);
        `CHK(d, 32'hDF9F_2385)
        wr(CAF_OFS_FILTER_CTRL_0, 32'h0000_4400);
        rd(CAF_OFS_FILTER_CTRL_0, d);
        `CHK(d, 32'h5F1F_4405)
        wr(CAF_OFS_FILTER_CTRL_1, 32'h0000_6013);
        rd(CAF_OFS_FILTER_CTRL_1, d);
        `CHK(d, 32'h0000_6000)
    endtask

    // mask codes, disabled filter, lowest index wins
    task automatic t_routing();
        logic [3:0] hit_tab;
        logic [31:0] d;
        hit_tab = 4'b0110;
        wr(CAF_OFS_FILTER_CTRL_0, 32'h0000_0000);
        wr(CAF_OFS_FILTER_CTRL_1, 32'h0000_0000);
        wr(CAF_OFS_MASK_0, 32'h1FFF_FFFF);
        wr(CAF_OFS_MASK_1, 32'h0000_0000);
        wr(CAF_OFS_MASK_2, 32'h1FFF_FFF0);
        wr(CAF_OFS_FILTER_ID_0, 32'h0000_0123);
        wr(CAF_OFS_FILTER_ID_0 + 8'h10, 32'h0000_0125);
        for (int c = 0; c < 4; c++) begin
            wr(CAF_OFS_FILTER_CTRL_0, {24'h0, fb(1, 2'(c), 5'(c + 28))});
            look(29'h12A, hit_tab[c], 3'h0, 5'(c + 28));
            wr(CAF_OFS_FILTER_CTRL_0, 32'h0000_0000);
        end
        look(29'h123, 1'b0, 3'h0, 5'h00);
        wr(CAF_OFS_FILTER_CTRL_0, {24'h0, fb(1, 2'h1, 5'h03)});
        wr(CAF_OFS_FILTER_CTRL_1, {24'h0, fb(1, 2'h1, 5'h1F)});
        look(29'h007, 1'b1, 3'h0, 5'h03);
        wr(CAF_OFS_FILTER_CTRL_0, 32'h0000_0000);
        look(29'h007, 1'b1, 3'h4, 5'h1F);
        // masks and identifiers read back; the identifier of an enabled filter ignores writes
        rd(CAF_OFS_MASK_2, d);
        `CHK(d, 32'h1FFF_FFF0)
        wr(CAF_OFS_FILTER_ID_0 + 8'h10, 32'h0000_0999);
        rd(CAF_OFS_FILTER_ID_0 + 8'h10, d);
        `CHK(d, 32'h0000_0125)
        // seven lookups so far, three of them missed
        rd(CAF_OFS_STATUS, d);
        `CHK(d, 32'h0000_0307)
    endtask

    // reset in mid-run clears every field, mask 2 and the lookup counters
    task automatic t_mid_reset();
        logic [31:0] d;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_reset_values();
        rd(CAF_OFS_MASK_2, d);
        `CHK(d, 32'h0000_0000)
        rd(CAF_OFS_STATUS, d);
        `CHK(d, 32'h0000_0000)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic final_report();
        $display("compares %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog: the tests need about a hundred cycles
    initial begin
        #(3000 * 50);
        num_errors++;
        final_report();
    end

    // main sequence: reset held for 4 cycles, then the scenarios
    initial begin
        resetn    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        msg_valid = 1'b0;
        msg_id    = 29'h0000_0000;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_reset_values();
        t_layout();
        t_lock();
        t_routing();
        t_mid_reset();
        final_report();
    end
endmodule
`default_nettype wire

/* File: caf_match.sv */
// single filter comparator: identifier match under the selected acceptance mask
`timescale 1ns/100ps
`default_nettype none
module caf_match
    import caf_pkg::*;
#(
    parameter int ID_W = CAF_ID_W
) (
    // filter setting and compare values
    input  wire logic [ID_W-1:0] msg_id,
    input  wire logic [ID_W-1:0] filt_id,
    input  wire logic [ID_W-1:0] mask_0,
    input  wire logic [ID_W-1:0] mask_1,
    input  wire logic [ID_W-1:0] mask_2,
    input  wire caf_filter_t     setting,
    // result
    output logic                 hit
);
    // elaboration check: an empty identifier cannot be compared
    if (ID_W < 1) begin : g_bad_id_w
        $error("caf_match: ID_W must be positive");
    end

    logic [ID_W-1:0] sel_mask;
    // reserved code selects an all-ones mask and is blocked in cmp_ok, so it never matches
    assign sel_mask = (setting.mask_choice == CAF_MASK_SEL_0) ? mask_0 :
                      (setting.mask_choice == CAF_MASK_SEL_1) ? mask_1 :
                      (setting.mask_choice == CAF_MASK_SEL_2) ? mask_2 : {ID_W{1'b1}}; // [R2]
    logic cmp_ok;
    assign cmp_ok = (((msg_id ^ filt_id) & sel_mask) == '0) && (setting.mask_choice != CAF_MASK_SEL_RSV);
    // a disabled filter never matches
    assign hit = setting.filter_on & cmp_ok; // [R1] [R10]
endmodule
`default_nettype wire

/* File: caf_pkg.sv */
// package: register map, field layout and shared types of the acceptance filter control block
package caf_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] CAF_OFS_FILTER_CTRL_0 = 8'h00;
    localparam logic [7:0] CAF_OFS_FILTER_CTRL_1 = 8'h04;
    localparam logic [7:0] CAF_OFS_MASK_0        = 8'h08;
    localparam logic [7:0] CAF_OFS_MASK_1        = 8'h0C;
    localparam logic [7:0] CAF_OFS_MASK_2        = 8'h10;
    localparam logic [7:0] CAF_OFS_FILTER_ID_0   = 8'h20;
    localparam logic [7:0] CAF_OFS_STATUS        = 8'h40;
    localparam int         CAF_ID_STRIDE         = 4;
    // field layout inside one filter byte, filter counts and identifier width
    localparam int CAF_NUM_FILTERS   = 6;
    localparam int CAF_FILTER_BITS   = 8;
    localparam int CAF_ON_POS        = 7;
    localparam int CAF_MASK_LSB      = 5;
    localparam int CAF_MASK_W        = 2;
    localparam int CAF_DEST_LSB      = 0;
    localparam int CAF_DEST_W        = 5;
    localparam int CAF_FILTERS_REG0  = 4;
    localparam int CAF_ID_W          = 29;
    // reset values
    localparam logic [31:0] CAF_CTRL_RESET = 32'h0000_0000;
    localparam logic [28:0] CAF_ID_RESET   = 29'h0000_0000;
    // mask choice codes
    localparam logic [1:0] CAF_MASK_SEL_0   = 2'h0;
    localparam logic [1:0] CAF_MASK_SEL_1   = 2'h1;
    localparam logic [1:0] CAF_MASK_SEL_2   = 2'h2;
    localparam logic [1:0] CAF_MASK_SEL_RSV = 2'h3;

    typedef struct packed {
        logic       filter_on;
        logic [1:0] mask_choice;
        logic [4:0] fifo_destination;
    } caf_filter_t;

    typedef struct packed {
        logic        hit;
        logic [2:0]  filter;
        logic [4:0]  fifo;
    } caf_route_t;
endpackage
